/* File: common/ivs_pkg.sv */
// constants, tables and helpers for the interrupt vector select block
// ****************************************************************
// ****************************************************************
package ivs_pkg;

   // ****************************************************************
   // table geometry
   // ****************************************************************
   localparam int          NUM_VECTORS   = 126;
   localparam int          NUM_TRAPS     = 8;
   localparam int          NUM_USER      = 118;
   localparam int          VEC_W         = 7;
   localparam int          ADDR_W        = 24;
   localparam int          LVL_W         = 4;
   localparam int          UPRIO_W       = 3;
   localparam logic [23:0] PRIMARY_BASE  = 24'h000004;
   localparam logic [23:0] ALTERNATE_BASE = 24'h000104;
   localparam logic [23:0] RESET_ADDR    = 24'h000000;
   localparam int          ALT_SEL_BIT   = 15;

   // ****************************************************************
   // priority levels
   // ****************************************************************
   localparam logic [3:0]  TRAP_TOP_LEVEL  = 4'hf;
   localparam logic [3:0]  TRAP_MIN_LEVEL  = 4'h8;
   localparam logic [3:0]  LEVEL_NONE      = 4'h0;

   // ****************************************************************
   // fixed latencies, in core clock cycles
   // ****************************************************************
   localparam logic [2:0]  ENTRY_LAT_CYC   = 3'h4;
   localparam logic [2:0]  RETURN_LAT_CYC  = 3'h3;

   // nesting stack holds one slot per level above zero
   localparam int          STACK_DEPTH     = 15;
   localparam logic [3:0]  STACK_FULL      = 4'hf;

   // traps carry fixed levels, vector 0 the highest
   function automatic logic [3:0] trap_level(input logic [6:0] vec);
      trap_level = TRAP_TOP_LEVEL - vec[3:0];
   endfunction : trap_level

   // base plus two words per vector
   function automatic logic [23:0] vector_addr(input logic       alt,
                                               input logic [6:0] vec);
      logic [23:0] base;
      base = alt ? ALTERNATE_BASE : PRIMARY_BASE;
      vector_addr = base + {16'h0000, vec, 1'b0};
   endfunction : vector_addr

endpackage : ivs_pkg

/* File: logic/ivs_arbiter.sv */
// combinational winner search over all vector sources
`timescale 1ns/1ps
`default_nettype none
module ivs_arbiter (
   // requests and priorities
   input  wire logic [125:0] req,
   input  wire logic [353:0] user_prio,
   // threshold
   input  wire logic [3:0]   threshold,
   // winner
   output logic              found,
   output logic [6:0]        win_vec,
   output logic [3:0]        win_lvl
);

   // ****************************************************************
   // search
   // ****************************************************************
   // scanning from the top with >= lets the lowest vector win a tie
   always_comb begin
      logic [3:0] lvl;
      lvl     = ivs_pkg::LEVEL_NONE;
      found   = 1'b0;
      win_vec = '0;
      win_lvl = ivs_pkg::LEVEL_NONE;
      for (int i = ivs_pkg::NUM_VECTORS - 1; i >= 0; i--) begin
         if (i < ivs_pkg::NUM_TRAPS) begin
            lvl = ivs_pkg::trap_level(7'(i));
         end else begin
            lvl = {1'b0, user_prio[(i - ivs_pkg::NUM_TRAPS) *
                                   ivs_pkg::UPRIO_W +:
                                   ivs_pkg::UPRIO_W]};
         end
         // zero priority can never beat any threshold
         if (req[i] && (lvl > threshold) && (lvl >= win_lvl)) begin
            found   = 1'b1;
            win_vec = 7'(i);
            win_lvl = lvl;
         end
      end
   end

endmodule : ivs_arbiter
`default_nettype wire

/* File: logic/ivs_vector_select.sv */
// interrupt request funnel and vector address selection
`timescale 1ns/1ps
`default_nettype none
module ivs_vector_select (
   // clock and reset
   input  wire logic         SYS_CLK,
   input  wire logic         RST,
   // source requests, vectors 0..7 are traps
   input  wire logic [125:0] SRC_REQ,
   // user priority, three bits per maskable source from vector 8
   input  wire logic [353:0] SRC_PRIO,
   // core side
   input  wire logic [3:0]   CORE_PRIORITY_LEVEL,
   input  wire logic         ALT_TABLE_SELECT,
   input  wire logic         CORE_ACK,
   input  wire logic         SERVICE_RETURN,
   // request toward the core
   output logic              IRQ,
   output logic [6:0]        VECTOR_NUM,
   output logic [3:0]        REQ_LEVEL,
   output logic [23:0]       VECTOR_ADDR,
   // service progress
   output logic              ENTRY_DONE,
   output logic              RETURN_DONE,
   output logic              TRAP_ACTIVE,
   output logic [3:0]        ACTIVE_LEVEL,
   output logic [3:0]        NEST_DEPTH
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef enum logic [1:0] {
      IVS_IDLE,
      IVS_PRESENT,
      IVS_ENTRY
   } ivs_mode_e;

   typedef struct packed {
      ivs_mode_e        mode;
      logic             irq;
      logic [6:0]       vec;
      logic [3:0]       lvl;
      logic [23:0]      addr;
      logic [2:0]       entry_cnt;
      logic             entry_done;
      logic             ret_busy;
      logic [2:0]       ret_cnt;
      logic             ret_done;
      logic [ivs_pkg::STACK_DEPTH-1:0][3:0] stack;
      logic [3:0]       depth;
      logic [3:0]       active;
      logic             trap_active;
   } ivs_state_s;

   ivs_state_s state_reg;
   ivs_state_s state_next;

   // ****************************************************************
   // arbitration
   // ****************************************************************
   logic       win_found;
   logic [6:0] win_vec;
   logic [3:0] win_lvl;
   logic [3:0] threshold;

   // a source equal to the one in service must wait, whatever its rank
   always_comb begin
      if ((state_reg.depth != 4'h0) &&
          (state_reg.active > CORE_PRIORITY_LEVEL)) begin
         threshold = state_reg.active;
      end else begin
         threshold = CORE_PRIORITY_LEVEL;
      end
   end

   ivs_arbiter u_arbiter (
      .req       (SRC_REQ),
      .user_prio (SRC_PRIO),
      .threshold (threshold),
      .found     (win_found),
      .win_vec   (win_vec),
      .win_lvl   (win_lvl)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic       pushing;
      logic       popping;
      logic [3:0] new_depth;
      pushing    = 1'b0;
      popping    = 1'b0;
      new_depth  = state_reg.depth;
      state_next = state_reg;
      state_next.entry_done = 1'b0;
      state_next.ret_done   = 1'b0;

      unique case (state_reg.mode)
         IVS_IDLE: begin
            if (win_found) begin
               state_next.mode = IVS_PRESENT;
               state_next.irq  = 1'b1;
               state_next.vec  = win_vec;
               state_next.lvl  = win_lvl;
               state_next.addr = ivs_pkg::vector_addr(ALT_TABLE_SELECT,
                                                      win_vec);
            end
         end
         IVS_PRESENT: begin
            if (CORE_ACK) begin
               // the core has taken the presented vector; freeze it
               state_next.mode      = IVS_ENTRY;
               state_next.irq       = 1'b0;
               state_next.entry_cnt = ivs_pkg::ENTRY_LAT_CYC;
               state_next.addr = ivs_pkg::vector_addr(ALT_TABLE_SELECT,
                                                      state_reg.vec);
            end else if (!win_found) begin
               // request withdrawn before the core took it
               state_next.mode = IVS_IDLE;
               state_next.irq  = 1'b0;
            end else if (win_lvl > state_reg.lvl) begin
               // only a strictly higher level may displace the offer
               state_next.vec  = win_vec;
               state_next.lvl  = win_lvl;
               state_next.addr = ivs_pkg::vector_addr(ALT_TABLE_SELECT,
                                                      win_vec);
            end else begin
               state_next.addr = ivs_pkg::vector_addr(ALT_TABLE_SELECT,
                                                      state_reg.vec);
            end
         end
         IVS_ENTRY: begin
            if (state_reg.entry_cnt == 3'h1) begin
               state_next.mode       = IVS_IDLE;
               state_next.entry_cnt  = 3'h0;
               state_next.entry_done = 1'b1;
               pushing               = 1'b1;
            end else begin
               state_next.entry_cnt = state_reg.entry_cnt - 3'h1;
            end
         end
      endcase

      // ****************************************************************
      // return path, same length for every source
      // ****************************************************************
      if (state_reg.ret_busy) begin
         if (state_reg.ret_cnt == 3'h1) begin
            state_next.ret_busy = 1'b0;
            state_next.ret_cnt  = 3'h0;
            state_next.ret_done = 1'b1;
            popping             = 1'b1;
         end else begin
            state_next.ret_cnt = state_reg.ret_cnt - 3'h1;
         end
      end else if (SERVICE_RETURN && (state_reg.depth != 4'h0)) begin
         state_next.ret_busy = 1'b1;
         state_next.ret_cnt  = ivs_pkg::RETURN_LAT_CYC;
      end

      // ****************************************************************
      // nesting stack of levels in service
      // ****************************************************************
      // push and pop in one cycle cancel: top swaps, depth holds
      if (pushing && popping) begin
         if (state_reg.depth != 4'h0) begin
            state_next.stack[state_reg.depth - 4'h1] = state_reg.lvl;
         end
      end else if (pushing) begin
         // a push onto a full stack cannot occur: each level nests at most once
         if (state_reg.depth != ivs_pkg::STACK_FULL) begin
            state_next.stack[state_reg.depth] = state_reg.lvl;
            new_depth = state_reg.depth + 4'h1;
         end
      end else if (popping) begin
         new_depth = state_reg.depth - 4'h1;
      end
      state_next.depth = new_depth;

      if (new_depth == 4'h0) begin
         state_next.active      = ivs_pkg::LEVEL_NONE;
         state_next.trap_active = 1'b0;
      end else begin
         state_next.active = state_next.stack[new_depth - 4'h1];
         state_next.trap_active =
            (state_next.stack[new_depth - 4'h1] >= ivs_pkg::TRAP_MIN_LEVEL);
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   // reset clears all state; nothing is fetched and no request leaves
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************************************
   // outputs, straight from the state register
   // ****************************************************************
   assign IRQ          = state_reg.irq;
   assign VECTOR_NUM   = state_reg.vec;
   assign REQ_LEVEL    = state_reg.lvl;
   assign VECTOR_ADDR  = state_reg.addr;
   assign ENTRY_DONE   = state_reg.entry_done;
   assign RETURN_DONE  = state_reg.ret_done;
   assign TRAP_ACTIVE  = state_reg.trap_active;
   assign ACTIVE_LEVEL = state_reg.active;
   assign NEST_DEPTH   = state_reg.depth;

endmodule : ivs_vector_select
`default_nettype wire

/* File: testbench/ivs_core_model.sv */
// core side model: takes requests and returns from routines
`timescale 1ns/1ps
`default_nettype none
module ivs_core_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // from the block
   input  wire logic       irq,
   // bench controls
   input  wire logic       ack_en,
   input  wire logic [3:0] ack_dly,
   input  wire logic       stray_ack,
   input  wire logic       ret_go,
   // toward the block
   output logic            core_ack,
   output logic            service_return
);
   logic [3:0] wait_reg;
   // only fetch addresses are seen here; table contents are software's
   // duty: defaults in unused slots, mirrored alternate table
   // a slow core holds off the ack to show the request stands
   always_ff @(posedge clk) begin
      if (rst) begin
         core_ack <= 1'b0;
         service_return <= 1'b0;
         wait_reg <= 4'h0;
      end else begin
         core_ack <= stray_ack |
                     (irq & ack_en & ~core_ack & (wait_reg >= ack_dly));
         wait_reg <= (irq & ~core_ack) ? wait_reg + 4'h1 : 4'h0;
         service_return <= ret_go;
      end
   end
endmodule : ivs_core_model
`default_nettype wire

/* File: testbench/ivs_vector_select_sva.sv */
// checker for request, vector address, entry and return timing
`timescale 1ns/1ps
`default_nettype none
module ivs_vector_select_sva (
   // clock and reset
   input wire logic        SYS_CLK,
   input wire logic        RST,
   // core side
   input wire logic [3:0]  CORE_PRIORITY_LEVEL,
   input wire logic        ALT_TABLE_SELECT,
   input wire logic        CORE_ACK,
   input wire logic        SERVICE_RETURN,
   // block outputs
   input wire logic        IRQ,
   input wire logic [6:0]  VECTOR_NUM,
   input wire logic [3:0]  REQ_LEVEL,
   input wire logic [23:0] VECTOR_ADDR,
   input wire logic        ENTRY_DONE,
   input wire logic        RETURN_DONE,
   input wire logic        TRAP_ACTIVE,
   input wire logic [3:0]  ACTIVE_LEVEL,
   input wire logic [3:0]  NEST_DEPTH
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   property p_addr;
      IRQ && $past(IRQ) && $stable(ALT_TABLE_SELECT) |->
         VECTOR_ADDR == (ALT_TABLE_SELECT ? 24'h000104 : 24'h000004) +
                        {16'h0000, VECTOR_NUM, 1'b0};
   endproperty
   a_addr: assert property (p_addr) else $error("vector address wrong");
   // ack edge loads a count of 4: done shows on the fifth sample
   property p_entry;
      IRQ && CORE_ACK |=> !ENTRY_DONE [*4] ##1 ENTRY_DONE;
   endproperty
   a_entry: assert property (p_entry) else $error("entry latency wrong");
   property p_drop;
      IRQ && CORE_ACK |=> !IRQ;
   endproperty
   a_drop: assert property (p_drop) else $error("request kept after ack");
   // return count of 3 plus the taking edge
   property p_ret;
      SERVICE_RETURN && NEST_DEPTH != 4'h0 && !$past(SERVICE_RETURN) &&
      !$past(SERVICE_RETURN, 2) && !$past(SERVICE_RETURN, 3) |->
         ##4 RETURN_DONE;
   endproperty
   a_ret: assert property (p_ret) else $error("return latency wrong");
   property p_thr;
      IRQ && !$past(IRQ) |-> REQ_LEVEL > $past(CORE_PRIORITY_LEVEL) &&
         ($past(NEST_DEPTH) == 4'h0 || REQ_LEVEL > $past(ACTIVE_LEVEL));
   endproperty
   a_thr: assert property (p_thr) else $error("request not above level");
   property p_hold;
      IRQ && $past(IRQ) |->
         VECTOR_NUM == $past(VECTOR_NUM) || REQ_LEVEL > $past(REQ_LEVEL);
   endproperty
   a_hold: assert property (p_hold) else $error("equal level replaced");
   property p_trap;
      TRAP_ACTIVE == (NEST_DEPTH != 4'h0 && ACTIVE_LEVEL >= 4'h8);
   endproperty
   a_trap: assert property (p_trap) else $error("trap flag wrong");
   property p_tlvl;
      IRQ && VECTOR_NUM < 7'h08 |-> REQ_LEVEL == 4'hf - VECTOR_NUM[3:0];
   endproperty
   a_tlvl: assert property (p_tlvl) else $error("trap level wrong");
   property p_rst;
      disable iff (1'b0) RST |=> !IRQ && !ENTRY_DONE &&
         NEST_DEPTH == 4'h0 && VECTOR_ADDR == 24'h000000;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   // the taken address is frozen until the next presentation
   property p_keep;
      !IRQ && !$past(CORE_ACK) |-> $stable(VECTOR_ADDR);
   endproperty
   a_keep: assert property (p_keep) else $error("fetch address moved");
endmodule : ivs_vector_select_sva
bind ivs_vector_select ivs_vector_select_sva u_sva (
   .SYS_CLK(SYS_CLK), .RST(RST), .CORE_PRIORITY_LEVEL(CORE_PRIORITY_LEVEL),
   .ALT_TABLE_SELECT(ALT_TABLE_SELECT), .CORE_ACK(CORE_ACK),
   .SERVICE_RETURN(SERVICE_RETURN), .IRQ(IRQ), .VECTOR_NUM(VECTOR_NUM),
   .REQ_LEVEL(REQ_LEVEL), .VECTOR_ADDR(VECTOR_ADDR),
   .ENTRY_DONE(ENTRY_DONE), .RETURN_DONE(RETURN_DONE),
   .TRAP_ACTIVE(TRAP_ACTIVE), .ACTIVE_LEVEL(ACTIVE_LEVEL),
   .NEST_DEPTH(NEST_DEPTH));
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the vector select block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic         SYS_CLK = 1'b0;
   logic         RST = 1'b1;
   logic [125:0] SRC_REQ = '0;
   logic [353:0] SRC_PRIO = '0;
   logic [3:0]   CORE_PRIORITY_LEVEL = 4'h0;
   logic         ALT_TABLE_SELECT = 1'b0;
   logic         ack_en = 1'b0, stray_ack = 1'b0, ret_go = 1'b0;
   logic [3:0]   ack_dly = 4'h0;
   logic         CORE_ACK, SERVICE_RETURN, IRQ, ENTRY_DONE, RETURN_DONE, TRAP_ACTIVE;
   logic [6:0]   VECTOR_NUM;
   logic [3:0]   REQ_LEVEL, ACTIVE_LEVEL, NEST_DEPTH;
   logic [23:0]  VECTOR_ADDR, ea;
   logic         got;
   int           failures = 0, checked = 0;
   typedef struct packed {
      logic [6:0] va; logic [2:0] pa; logic [6:0] vb; logic [2:0] pb;
      logic [3:0] core; logic alt; logic irq; logic [6:0] vec; logic [3:0] lvl;
   } ivs_row_s;
   // a, prio, b, prio, core level, alt, request, winner, level
   ivs_row_s rows [8] = '{
      '{7'h00, 3'h0, 7'h7f, 3'h0, 4'h0, 1'b0, 1'b1, 7'h00, 4'hf},
      '{7'h7d, 3'h7, 7'h7f, 3'h0, 4'h0, 1'b1, 1'b1, 7'h7d, 4'h7},
      '{7'h1e, 3'h3, 7'h14, 3'h3, 4'h0, 1'b0, 1'b1, 7'h14, 4'h3},
      '{7'h14, 3'h2, 7'h28, 3'h5, 4'h0, 1'b1, 1'b1, 7'h28, 4'h5},
      '{7'h09, 3'h0, 7'h7f, 3'h0, 4'h0, 1'b0, 1'b0, 7'h00, 4'h0},
      '{7'h32, 3'h4, 7'h7f, 3'h0, 4'h4, 1'b0, 1'b0, 7'h00, 4'h0},
      '{7'h32, 3'h4, 7'h7f, 3'h0, 4'h3, 1'b0, 1'b1, 7'h32, 4'h4},
      '{7'h08, 3'h7, 7'h03, 3'h0, 4'h7, 1'b1, 1'b1, 7'h03, 4'hc}};
   always #12.5 SYS_CLK = ~SYS_CLK;
   ivs_vector_select DUT (
      .SYS_CLK(SYS_CLK), .RST(RST), .SRC_REQ(SRC_REQ), .SRC_PRIO(SRC_PRIO),
      .CORE_PRIORITY_LEVEL(CORE_PRIORITY_LEVEL),
      .ALT_TABLE_SELECT(ALT_TABLE_SELECT), .CORE_ACK(CORE_ACK),
      .SERVICE_RETURN(SERVICE_RETURN), .IRQ(IRQ), .VECTOR_NUM(VECTOR_NUM),
      .REQ_LEVEL(REQ_LEVEL), .VECTOR_ADDR(VECTOR_ADDR),
      .ENTRY_DONE(ENTRY_DONE), .RETURN_DONE(RETURN_DONE),
      .TRAP_ACTIVE(TRAP_ACTIVE), .ACTIVE_LEVEL(ACTIVE_LEVEL),
      .NEST_DEPTH(NEST_DEPTH));
   ivs_core_model u_core (
      .clk(SYS_CLK), .rst(RST), .irq(IRQ), .ack_en(ack_en),
      .ack_dly(ack_dly), .stray_ack(stray_ack), .ret_go(ret_go),
      .core_ack(CORE_ACK), .service_return(SERVICE_RETURN));
   task automatic chk(input string nm, input logic [23:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic print_verdict();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict
   task automatic wait_on(input int sel, output logic g);
      g = 1'b0;
      for (int i = 0; i < 12 && g !== 1'b1; i++) begin
         @(posedge SYS_CLK);
         #1;
         g = (sel == 0) ? IRQ : (sel == 1) ? ENTRY_DONE : RETURN_DONE;
      end
   endtask : wait_on
   // one edge, one write of each vector; 7'h7f means no source
   task automatic set_src(input logic [6:0] va, vb, input logic [2:0] pa, pb);
      logic [125:0] r;
      logic [353:0] p;
      r = '0;
      p = '0;
      if (va < 7'h7e) r[va] = 1'b1;
      if (vb < 7'h7e) r[vb] = 1'b1;
      if (va >= 7'h08 && va < 7'h7e) p[(va - 8) * 3 +: 3] = pa;
      if (vb >= 7'h08 && vb < 7'h7e) p[(vb - 8) * 3 +: 3] = pb;
      @(posedge SYS_CLK);
      SRC_REQ <= r;
      SRC_PRIO <= p;
   endtask : set_src
   task automatic serve(input logic [3:0] dly, lvl);
      logic g;
      @(posedge SYS_CLK);
      ack_dly <= dly;
      ack_en <= 1'b1;
      wait_on(1, g);
      chk("entry", g, 1'b1);
      chk("active", ACTIVE_LEVEL, lvl);
      chk("trap", TRAP_ACTIVE, lvl >= 4'h8);
      @(posedge SYS_CLK) ack_en <= 1'b0;
   endtask : serve
   task automatic ret(input logic [3:0] depth);
      logic g;
      @(posedge SYS_CLK) ret_go <= 1'b1;
      @(posedge SYS_CLK) ret_go <= 1'b0;
      wait_on(2, g);
      chk("return", g, 1'b1);
      chk("depth", NEST_DEPTH, depth);
   endtask : ret
   initial begin
      #100000;
      failures++;
      print_verdict();
   end
   initial begin
      repeat (12) @(posedge SYS_CLK);
      RST <= 1'b0;
      #1;
      chk("irq_rst", IRQ, 1'b0);
      for (int i = 0; i < 8; i++) begin
         @(posedge SYS_CLK);
         CORE_PRIORITY_LEVEL <= rows[i].core;
         ALT_TABLE_SELECT <= rows[i].alt;
         set_src(rows[i].va, rows[i].vb, rows[i].pa, rows[i].pb);
         wait_on(0, got);
         chk("irq", got, rows[i].irq);
         if (rows[i].irq) begin
            ea = (rows[i].alt ? 24'h000104 : 24'h000004) + {rows[i].vec, 1'b0};
            chk("vector", VECTOR_NUM, rows[i].vec);
            chk("level", REQ_LEVEL, rows[i].lvl);
            chk("addr", VECTOR_ADDR, ea);
            serve(4'(i % 3), rows[i].lvl);
            set_src(7'h7f, 7'h7f, 3'h0, 3'h0);
            ret(4'h0);
         end else set_src(7'h7f, 7'h7f, 3'h0, 3'h0);
      end
      // equal level with better rank waits; higher level nests
      @(posedge SYS_CLK) CORE_PRIORITY_LEVEL <= 4'h0;
      set_src(7'h14, 7'h7f, 3'h3, 3'h0);
      wait_on(0, got);
      serve(4'h2, 4'h3);
      set_src(7'h0a, 7'h7f, 3'h3, 3'h0);
      wait_on(0, got);
      chk("irq_wait", got, 1'b0);
      set_src(7'h0a, 7'h1e, 3'h3, 3'h5);
      wait_on(0, got);
      chk("nest_vec", VECTOR_NUM, 7'h1e);
      serve(4'h0, 4'h5);
      chk("nest_depth", NEST_DEPTH, 4'h2);
      set_src(7'h0a, 7'h7f, 3'h3, 3'h0);
      ret(4'h1);
      wait_on(0, got);
      chk("irq_wait2", got, 1'b0);
      ret(4'h0);
      wait_on(0, got);
      chk("late_vec", VECTOR_NUM, 7'h0a);
      // reset in mid-run, then an ack with no request is refused
      @(posedge SYS_CLK) RST <= 1'b1;
      set_src(7'h7f, 7'h7f, 3'h0, 3'h0);
      #1;
      chk("rst_irq", IRQ, 1'b0);
      chk("rst_depth", NEST_DEPTH, 4'h0);
      chk("rst_addr", VECTOR_ADDR, 24'h000000);
      @(posedge SYS_CLK) RST <= 1'b0;
      @(posedge SYS_CLK) stray_ack <= 1'b1;
      @(posedge SYS_CLK) stray_ack <= 1'b0;
      wait_on(1, got);
      chk("stray", got, 1'b0);
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
